// [hdl/cardbus_window_pkg.sv]
// Purpose: Constants for the CardBus bridge window decode registers
// Assumes: Dword configuration addressing with byte enables
// Notes: Offsets are byte offsets in configuration space
package cardbus_window_pkg;
   // ****************************************************
   // Configuration offsets
   // ****************************************************
   localparam logic [7:0] OFF_BUS_NUMBERS = 8'h18; // Bus, CardBus bus, subordinate, latency
   localparam logic [7:0] OFF_SUB_BUS = 8'h1A; // Subordinate bus number byte
   localparam logic [7:0] OFF_LATENCY = 8'h1B; // CardBus latency byte
   localparam logic [7:0] OFF_MEM0_BASE = 8'h1C;
   localparam logic [7:0] OFF_MEM0_LIMIT = 8'h20;
   localparam logic [7:0] OFF_MEM1_BASE = 8'h24;
   localparam logic [7:0] OFF_MEM1_LIMIT = 8'h28;
   localparam logic [7:0] OFF_IO0_BASE = 8'h2C;
   localparam logic [7:0] OFF_IO0_LIMIT = 8'h30;
   localparam logic [7:0] OFF_IO1_BASE = 8'h34;
   localparam logic [7:0] OFF_IO1_LIMIT = 8'h38;
   // ****************************************************
   // Field masks and reset values
   // ****************************************************
   localparam logic [31:0] MEM_WR_MASK = 32'hFFFFF000; // Bits 31-12 writable
   localparam logic [31:0] MEM_LOW_ONES = 32'h00000FFF; // Limit low bits taken as ones
   localparam logic [31:0] IO_WR_MASK = 32'h0000FFFC; // Bits 15-2 writable
   localparam logic [31:0] IO_LOW_ONES = 32'h00000003; // Limit low bits taken as ones
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int NUM_FUNC = 2; // CardBus controller functions
   localparam logic [7:0] LAT_RECOMMENDED = 8'h20; // Suggested latency minimum
endpackage

// [hdl/cardbus_window_decode_regs.sv]
// Purpose: Bus numbers, latency timer and memory/IO window decode per function
// Assumes: Config access, decode queries and CardBus events are on clock
// Notes: Decode answers are registered one cycle after the query
// Function
// - Subordinate bus number steers config forwarding
// - Each function owns its own bus registers
// - Latency count starts when CFRAME asserted
// - Expired count ends transaction at next data
// - Memory base is window lower bound
// - Memory limit is window upper bound
// - Memory bits 31-12 writable, 11-0 zero
// - Bridge control bits 8, 9 set prefetchable
// - Memory window claims only if base/limit nonzero
// - IO base is IO window lower bound
// - IO bits 15-2 writable, others read zero
// - IO window enabled only if base/limit nonzero
// - IO limit low two bits taken as ones
`timescale 1ns/1ps
`default_nettype none
module cardbus_window_decode_regs (
   input wire logic clock,
   input wire logic resetn,
   // Configuration access
   input wire logic cfgFunc, // Function selected
   input wire logic [7:0] cfgAddr, // Byte offset, dword aligned use
   input wire logic cfgWrite, // Write strobe
   input wire logic cfgRead, // Read strobe
   input wire logic [3:0] cfgByteEn, // Byte enables, active high
   input wire logic [31:0] cfgWriteData,
   output logic [31:0] cfgReadData,
   output logic cfgReadValid,
   // Bridge control prefetch bits per function
   input wire logic [1:0] memWin0Prefetchable,
   input wire logic [1:0] memWin1Prefetchable,
   // Decode query
   input wire logic decodeFunc,
   input wire logic [31:0] decodeAddr,
   input wire logic [7:0] decodeBus,
   output logic [1:0] memWinHit,
   output logic memHitPrefetch,
   output logic [1:0] ioWinHit,
   output logic cfgType0Fwd,
   output logic cfgType1Fwd,
   // CardBus initiator tracking
   input wire logic latFunc,
   input wire logic frameAssert, // CFRAME asserted by this device
   input wire logic dataPhaseDone,
   input wire logic transDone,
   output logic latencyExpired,
   output logic endTransaction
);
   // ****************************************************
   // Reset synchroniser
   // ****************************************************
   logic rstSync1_reg; // First stage, read only by second
   logic rstSync2_reg; // Released reset
   // Two-flop release of asynchronous reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstSync1_reg <= 1'b0;
         rstSync2_reg <= 1'b0;
      end else begin
         rstSync1_reg <= 1'b1;
         rstSync2_reg <= rstSync1_reg;
      end
   end
   wire logic rstN = rstSync2_reg; // Internal active low reset

   // ****************************************************
   // Register storage per function
   // ****************************************************
   logic [7:0] pciBus_reg [cardbus_window_pkg::NUM_FUNC]; // Primary bus number
   logic [7:0] cardBus_reg [cardbus_window_pkg::NUM_FUNC]; // CardBus bus number
   logic [7:0] subBus_reg [cardbus_window_pkg::NUM_FUNC]; // Subordinate bus number
   logic [7:0] latency_reg [cardbus_window_pkg::NUM_FUNC]; // Latency count value
   logic [31:0] memBase_reg [cardbus_window_pkg::NUM_FUNC][2];
   logic [31:0] memLimit_reg [cardbus_window_pkg::NUM_FUNC][2];
   logic [31:0] ioBase_reg [cardbus_window_pkg::NUM_FUNC][2];
   logic [31:0] ioLimit_reg [cardbus_window_pkg::NUM_FUNC][2];

   // Merge write data into a word under byte enables and a writable mask
   function automatic logic [31:0] mergeWord(input logic [31:0] oldVal,
         input logic [31:0] newVal, input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] laneMask;
      laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      return (oldVal & ~laneMask) | (newVal & laneMask);
   endfunction

   // Dword decode of the access address
   wire logic [7:0] dwAddr = {cfgAddr[7:2], 2'b00};
   wire logic hitBusNum = (dwAddr == cardbus_window_pkg::OFF_BUS_NUMBERS);
   wire logic hitMem0B = (dwAddr == cardbus_window_pkg::OFF_MEM0_BASE);
   wire logic hitMem0L = (dwAddr == cardbus_window_pkg::OFF_MEM0_LIMIT);
   wire logic hitMem1B = (dwAddr == cardbus_window_pkg::OFF_MEM1_BASE);
   wire logic hitMem1L = (dwAddr == cardbus_window_pkg::OFF_MEM1_LIMIT);
   wire logic hitIo0B = (dwAddr == cardbus_window_pkg::OFF_IO0_BASE);
   wire logic hitIo0L = (dwAddr == cardbus_window_pkg::OFF_IO0_LIMIT);
   wire logic hitIo1B = (dwAddr == cardbus_window_pkg::OFF_IO1_BASE);
   wire logic hitIo1L = (dwAddr == cardbus_window_pkg::OFF_IO1_LIMIT);

   genvar f;
   generate
      for (f = 0; f < cardbus_window_pkg::NUM_FUNC; f++) begin : gFunc
         // Write only touches the addressed function
         wire logic wrFunc = cfgWrite && (cfgFunc == f[0]);
         // Byte registers of the bus-number dword
         always_ff @(posedge clock or negedge rstN) begin
            if (!rstN) begin
               pciBus_reg[f] <= cardbus_window_pkg::BYTE_RESET;
               cardBus_reg[f] <= cardbus_window_pkg::BYTE_RESET;
               subBus_reg[f] <= cardbus_window_pkg::BYTE_RESET;
               latency_reg[f] <= cardbus_window_pkg::BYTE_RESET;
            end else if (wrFunc && hitBusNum) begin
               if (cfgByteEn[0]) begin
                  pciBus_reg[f] <= cfgWriteData[7:0];
               end
               if (cfgByteEn[1]) begin
                  cardBus_reg[f] <= cfgWriteData[15:8];
               end
               if (cfgByteEn[2]) begin
                  subBus_reg[f] <= cfgWriteData[23:16];
               end
               if (cfgByteEn[3]) begin
                  latency_reg[f] <= cfgWriteData[31:24];
               end
            end
         end
         // Window words, masked to their writable fields
         always_ff @(posedge clock or negedge rstN) begin
            if (!rstN) begin
               memBase_reg[f][0] <= cardbus_window_pkg::WORD_RESET;
               memLimit_reg[f][0] <= cardbus_window_pkg::WORD_RESET;
               memBase_reg[f][1] <= cardbus_window_pkg::WORD_RESET;
               memLimit_reg[f][1] <= cardbus_window_pkg::WORD_RESET;
               ioBase_reg[f][0] <= cardbus_window_pkg::WORD_RESET;
               ioLimit_reg[f][0] <= cardbus_window_pkg::WORD_RESET;
               ioBase_reg[f][1] <= cardbus_window_pkg::WORD_RESET;
               ioLimit_reg[f][1] <= cardbus_window_pkg::WORD_RESET;
            end else if (wrFunc) begin
               if (hitMem0B) begin
                  memBase_reg[f][0] <= mergeWord(memBase_reg[f][0], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::MEM_WR_MASK);
               end
               if (hitMem0L) begin
                  memLimit_reg[f][0] <= mergeWord(memLimit_reg[f][0], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::MEM_WR_MASK);
               end
               if (hitMem1B) begin
                  memBase_reg[f][1] <= mergeWord(memBase_reg[f][1], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::MEM_WR_MASK);
               end
               if (hitMem1L) begin
                  memLimit_reg[f][1] <= mergeWord(memLimit_reg[f][1], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::MEM_WR_MASK);
               end
               if (hitIo0B) begin
                  ioBase_reg[f][0] <= mergeWord(ioBase_reg[f][0], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::IO_WR_MASK);
               end
               if (hitIo0L) begin
                  ioLimit_reg[f][0] <= mergeWord(ioLimit_reg[f][0], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::IO_WR_MASK);
               end
               if (hitIo1B) begin
                  ioBase_reg[f][1] <= mergeWord(ioBase_reg[f][1], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::IO_WR_MASK);
               end
               if (hitIo1L) begin
                  ioLimit_reg[f][1] <= mergeWord(ioLimit_reg[f][1], cfgWriteData, cfgByteEn,
                     cardbus_window_pkg::IO_WR_MASK);
               end
            end
         end
      end
   endgenerate

   // ****************************************************
   // Configuration read
   // ****************************************************
   logic [31:0] readMux; // Selected word
   // Read multiplexer, unmapped offsets read zero
   always_comb begin
      readMux = 32'h00000000;
      if (hitBusNum) begin
         readMux = {latency_reg[cfgFunc], subBus_reg[cfgFunc], cardBus_reg[cfgFunc],
            pciBus_reg[cfgFunc]};
      end else if (hitMem0B) begin
         readMux = memBase_reg[cfgFunc][0];
      end else if (hitMem0L) begin
         readMux = memLimit_reg[cfgFunc][0];
      end else if (hitMem1B) begin
         readMux = memBase_reg[cfgFunc][1];
      end else if (hitMem1L) begin
         readMux = memLimit_reg[cfgFunc][1];
      end else if (hitIo0B) begin
         readMux = ioBase_reg[cfgFunc][0];
      end else if (hitIo0L) begin
         readMux = ioLimit_reg[cfgFunc][0];
      end else if (hitIo1B) begin
         readMux = ioBase_reg[cfgFunc][1];
      end else if (hitIo1L) begin
         readMux = ioLimit_reg[cfgFunc][1];
      end
   end
   // Register read answer
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         cfgReadData <= 32'h00000000;
         cfgReadValid <= 1'b0;
      end else begin
         cfgReadValid <= cfgRead;
         cfgReadData <= cfgRead ? readMux : 32'h00000000;
      end
   end

   // ****************************************************
   // Window decode
   // ****************************************************
   logic [1:0] memHitNext; // Memory window hits
   logic [1:0] ioHitNext; // IO window hits
   genvar w;
   generate
      for (w = 0; w < 2; w++) begin : gWin
         wire logic [31:0] mBase = memBase_reg[decodeFunc][w];
         wire logic [31:0] mLim = memLimit_reg[decodeFunc][w] | cardbus_window_pkg::MEM_LOW_ONES;
         wire logic mEn = (memBase_reg[decodeFunc][w] != 32'h00000000) ||
            (memLimit_reg[decodeFunc][w] != 32'h00000000);
         // Lower and upper bound of the memory window
         assign memHitNext[w] = mEn && (decodeAddr >= mBase) &&
            (decodeAddr <= mLim);
         wire logic [31:0] iBase = ioBase_reg[decodeFunc][w];
         wire logic [31:0] iLim = ioLimit_reg[decodeFunc][w] |
            cardbus_window_pkg::IO_LOW_ONES;
         wire logic iEn = (ioBase_reg[decodeFunc][w] != 32'h00000000) ||
            (ioLimit_reg[decodeFunc][w] != 32'h00000000);
         // IO window in the first 64K page
         assign ioHitNext[w] = iEn && (decodeAddr >= iBase) && (decodeAddr <= iLim);
      end
   endgenerate
   // Prefetch attribute of the window that hit
   wire logic prefNext = (memHitNext[0] && memWin0Prefetchable[decodeFunc]) ||
      (memHitNext[1] && memWin1Prefetchable[decodeFunc]);
   // Config forwarding, never toward the primary bus itself
   wire logic notPrimary = (decodeBus != pciBus_reg[decodeFunc]);
   wire logic type0Next = notPrimary && (decodeBus == cardBus_reg[decodeFunc]);
   wire logic type1Next = notPrimary && (decodeBus > cardBus_reg[decodeFunc]) &&
      (decodeBus <= subBus_reg[decodeFunc]);
   // Register decode answers
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         memWinHit <= 2'b00;
         memHitPrefetch <= 1'b0;
         ioWinHit <= 2'b00;
         cfgType0Fwd <= 1'b0;
         cfgType1Fwd <= 1'b0;
      end else begin
         memWinHit <= memHitNext;
         memHitPrefetch <= prefNext;
         ioWinHit <= ioHitNext;
         cfgType0Fwd <= type0Next;
         cfgType1Fwd <= type1Next;
      end
   end

   // ****************************************************
   // Cardbus_latency_count
   // ****************************************************
   logic [7:0] latCount_reg; // Cycles since CFRAME
   logic [7:0] latLimit_reg; // Value captured at CFRAME
   logic latActive_reg; // Own transaction in progress
   wire logic [7:0] latCountInc = latCount_reg + 8'h01;
   wire logic expireNext = latActive_reg && !latencyExpired &&
      (latCountInc >= latLimit_reg);
   // Count cycles from CFRAME against the programmed value
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         latCount_reg <= 8'h00;
         latLimit_reg <= 8'h00;
         latActive_reg <= 1'b0;
         latencyExpired <= 1'b0;
      end else if (frameAssert) begin
         latCount_reg <= 8'h00;
         latLimit_reg <= latency_reg[latFunc];
         latActive_reg <= 1'b1;
         latencyExpired <= 1'b0;
      end else if (transDone || endTransaction) begin
         latActive_reg <= 1'b0;
         latencyExpired <= 1'b0;
      end else if (latActive_reg) begin
         if (!latencyExpired) begin
            latCount_reg <= latCountInc;
         end
         latencyExpired <= latencyExpired || expireNext;
      end
   end
   // Forced end at the next completed data phase after expiry
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         endTransaction <= 1'b0;
      end else begin
         endTransaction <= latActive_reg && latencyExpired && dataPhaseDone &&
            !transDone && !endTransaction && !frameAssert;
      end
   end
endmodule
`default_nettype wire

// [test/cardbus_card_model.sv]
// Purpose: Card side activity that drives the latency timer inputs
// Assumes: Changes on the falling edge, one transaction per go pulse
// Notes: Slow partner, one data phase every other cycle
`timescale 1ns/1ps
`default_nettype none
module cardbus_card_model (
   input wire logic clock,
   input wire logic go,
   input wire logic [3:0] len,
   input wire logic endTransaction,
   output logic frameAssert,
   output logic dataPhaseDone,
   output logic transDone
);
   // ****************************************
   // Transaction sequencer
   // ****************************************
   logic busy; // A transaction is open
   logic [4:0] left; // Data phases still owed
   initial begin
      {frameAssert, dataPhaseDone, transDone, busy, left} = '0;
   end
   // Frame, spaced data phases, normal end unless cut short
   always @(negedge clock) begin
      frameAssert <= go && !busy;
      dataPhaseDone <= busy && !dataPhaseDone && left != 0 && !endTransaction;
      transDone <= busy && left == 0 && !transDone;
      if (go && !busy) begin
         busy <= 1'b1;
         left <= {1'b0, len};
      end else if (dataPhaseDone) begin
         left <= left - 5'h01;
      end
      // Forced end stops further phases
      if (endTransaction || transDone) begin
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [test/cardbus_window_decode_regs_chk.sv]
// Purpose: Port-level assertions for the window decode block
// Assumes: Single clock domain, reset raw at the port
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module cardbus_window_decode_regs_chk (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] cfgAddr,
   input wire logic cfgRead,
   input wire logic [31:0] cfgReadData,
   input wire logic cfgReadValid,
   input wire logic [1:0] memWin0Prefetchable,
   input wire logic [1:0] memWin1Prefetchable,
   input wire logic decodeFunc,
   input wire logic [1:0] memWinHit,
   input wire logic memHitPrefetch,
   input wire logic cfgType0Fwd,
   input wire logic cfgType1Fwd,
   input wire logic frameAssert,
   input wire logic dataPhaseDone,
   input wire logic latencyExpired,
   input wire logic endTransaction
);
   // ****************************************
   // Helpers and sequences
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   wire logic pf0 = memWin0Prefetchable[decodeFunc]; // Selected prefetch bit
   wire logic pf1 = memWin1Prefetchable[decodeFunc]; // Selected prefetch bit, window 1
   sequence rdReq;
      cfgRead;
   endsequence
   sequence expPhase;
      latencyExpired && dataPhaseDone && !endTransaction && !frameAssert;
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   read_answer_a: assert property (rdReq |=> cfgReadValid)
      else $error("read not answered");
   valid_cause_a: assert property (cfgReadValid |-> $past(cfgRead))
      else $error("read valid without request");
   mem_low_zero_a: assert property (cfgReadValid &&
      $past(cfgAddr[7:2]) inside {[6'h07:6'h0A]}
      |-> cfgReadData[11:0] == 12'h000) else $error("memory low bits not zero");
   io_fixed_zero_a: assert property (cfgReadValid &&
      $past(cfgAddr[7:2]) inside {[6'h0B:6'h0E]}
      |-> cfgReadData[31:16] == 16'h0000 && cfgReadData[1:0] == 2'h0) else $error("io bits");
   fwd_exclusive_a: assert property (!(cfgType0Fwd && cfgType1Fwd))
      else $error("both forward types");
   prefetch_hit_a: assert property (memHitPrefetch |-> memWinHit != 2'b00)
      else $error("prefetch without hit");
   prefetch_sel_a: assert property (memWinHit[0] && $past(pf0) |-> memHitPrefetch)
      else $error("prefetch bit ignored");
   prefetch_win1_a: assert property (memWinHit[1] && $past(pf1) |-> memHitPrefetch)
      else $error("window 1 prefetch bit ignored");
   end_on_phase_a: assert property (expPhase |=> endTransaction)
      else $error("no end after expiry");
   end_cause_a: assert property (endTransaction |->
      $past(dataPhaseDone) && $past(latencyExpired)) else $error("end without cause");
   end_single_a: assert property (endTransaction |=> !endTransaction && !latencyExpired)
      else $error("end not single");
endmodule
bind cardbus_window_decode_regs cardbus_window_decode_regs_chk chk (.clock(clock), .resetn(resetn),
   .cfgAddr(cfgAddr), .cfgRead(cfgRead), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
   .memWin0Prefetchable(memWin0Prefetchable), .memWin1Prefetchable(memWin1Prefetchable),
   .decodeFunc(decodeFunc), .memWinHit(memWinHit), .memHitPrefetch(memHitPrefetch),
   .cfgType0Fwd(cfgType0Fwd), .cfgType1Fwd(cfgType1Fwd), .frameAssert(frameAssert),
   .dataPhaseDone(dataPhaseDone), .latencyExpired(latencyExpired), .endTransaction(endTransaction));
`default_nettype wire

// [test/cardbus_window_decode_regs_test.sv]
// Purpose: Random and corner tests of registers, decode and latency
// Assumes: Inputs change on the falling edge
// Notes: Shadow copy of the registers gives the register and decode expectations
`timescale 1ns/1ps
`default_nettype none
module cardbus_window_decode_regs_test;
   logic clock, resetn, cfgFunc, cfgWrite, cfgRead, decodeFunc, latFunc, go;
   logic [7:0] cfgAddr, decodeBus;
   logic [3:0] cfgByteEn, len;
   logic [31:0] cfgWriteData, decodeAddr, cfgReadData, b, z;
   logic [1:0] memWin0Prefetchable, memWin1Prefetchable, memWinHit, ioWinHit;
   logic cfgReadValid, memHitPrefetch, cfgType0Fwd, cfgType1Fwd, f;
   logic frameAssert, dataPhaseDone, transDone, latencyExpired, endTransaction;
   logic [31:0] shadow [2][9]; // Expected contents per function
   int n_errors, checked, k, w;
   // Mapped offsets, bus numbers first
   localparam logic [7:0] OFFS [9] = '{cardbus_window_pkg::OFF_BUS_NUMBERS,
      cardbus_window_pkg::OFF_MEM0_BASE, cardbus_window_pkg::OFF_MEM0_LIMIT,
      cardbus_window_pkg::OFF_MEM1_BASE, cardbus_window_pkg::OFF_MEM1_LIMIT,
      cardbus_window_pkg::OFF_IO0_BASE, cardbus_window_pkg::OFF_IO0_LIMIT,
      cardbus_window_pkg::OFF_IO1_BASE, cardbus_window_pkg::OFF_IO1_LIMIT};
   cardbus_window_decode_regs uut (.clock(clock), .resetn(resetn), .cfgFunc(cfgFunc),
      .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgByteEn(cfgByteEn),
      .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
      .memWin0Prefetchable(memWin0Prefetchable), .memWin1Prefetchable(memWin1Prefetchable),
      .decodeFunc(decodeFunc), .decodeAddr(decodeAddr), .decodeBus(decodeBus),
      .memWinHit(memWinHit), .memHitPrefetch(memHitPrefetch), .ioWinHit(ioWinHit),
      .cfgType0Fwd(cfgType0Fwd), .cfgType1Fwd(cfgType1Fwd), .latFunc(latFunc),
      .frameAssert(frameAssert), .dataPhaseDone(dataPhaseDone), .transDone(transDone),
      .latencyExpired(latencyExpired), .endTransaction(endTransaction));
   cardbus_card_model card (.clock(clock), .go(go), .len(len), .endTransaction(endTransaction),
      .frameAssert(frameAssert), .dataPhaseDone(dataPhaseDone), .transDone(transDone));
   // ****************************************
   // Clock, checking and closing
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************
   // Expectations and bus tasks
   // ****************************************
   function automatic int idx(input logic [7:0] a);
      for (int i = 0; i < 9; i++) if (OFFS[i] == a) return i;
      return 9;
   endfunction
   function automatic logic [6:0] exp_dec(input logic fn, input logic [31:0] a,
      input logic [7:0] bu);
      logic [1:0] m, io;
      logic [31:0] s;
      for (int i = 0; i < 2; i++) begin
         m[i] = (shadow[fn][1+2*i] | shadow[fn][2+2*i]) != 0 && a >= shadow[fn][1+2*i]
            && a <= (shadow[fn][2+2*i] | cardbus_window_pkg::MEM_LOW_ONES);
         io[i] = (shadow[fn][5+2*i] | shadow[fn][6+2*i]) != 0 && a >= shadow[fn][5+2*i]
            && a <= (shadow[fn][6+2*i] | cardbus_window_pkg::IO_LOW_ONES);
      end
      s = shadow[fn][0];
      return {bu > s[15:8] && bu <= s[23:16] && bu != s[7:0], bu == s[15:8] && bu != s[7:0],
         |(m & {memWin1Prefetchable[fn], memWin0Prefetchable[fn]}), io, m};
   endfunction
   task automatic cfg_write(input logic fn, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      {cfgFunc, cfgAddr, cfgWriteData, cfgByteEn, cfgWrite} = {fn, a, d, be, 1'b1};
      @(negedge clock);
      cfgWrite = 1'b0;
      if (idx(a) == 0) shadow[fn][0] = (shadow[fn][0] & ~m) | (d & m);
      else if (idx(a) < 5) shadow[fn][idx(a)] = (shadow[fn][idx(a)] & ~m)
         | (d & m & cardbus_window_pkg::MEM_WR_MASK);
      else if (idx(a) < 9) shadow[fn][idx(a)] = (shadow[fn][idx(a)] & ~m)
         | (d & m & cardbus_window_pkg::IO_WR_MASK);
      @(negedge clock);
   endtask
   task automatic cfg_check(input logic fn, input logic [7:0] a);
      {cfgFunc, cfgAddr, cfgRead} = {fn, a, 1'b1};
      @(negedge clock);
      cfgRead = 1'b0;
      check({31'h0, cfgReadValid}, 32'h1);
      check(cfgReadData, idx(a) < 9 ? shadow[fn][idx(a)] : 32'h0);
      @(negedge clock);
   endtask
   task automatic decode(input logic fn, input logic [31:0] a, input logic [7:0] bu);
      logic [6:0] e;
      {decodeFunc, decodeAddr, decodeBus} = {fn, a, bu};
      {memWin1Prefetchable, memWin0Prefetchable} = 4'($urandom);
      e = exp_dec(fn, a, bu);
      @(negedge clock);
      check({28'h0, ioWinHit, memWinHit}, {28'h0, e[3:0]});
      check({29'h0, cfgType1Fwd, cfgType0Fwd, memHitPrefetch}, {29'h0, e[6:4]});
   endtask
   task automatic run_tx(input logic fn, input logic [7:0] lat, input logic [3:0] n,
      input logic en);
      int c, cExp;
      logic seenEnd;
      cfg_write(fn, OFFS[0], {lat, 24'h0}, 4'h8);
      latFunc = fn;
      len = n;
      go <= 1'b1;
      @(negedge clock);
      go <= 1'b0;
      {c, cExp, seenEnd} = '0;
      repeat (30) begin
         @(negedge clock);
         if (frameAssert === 1'b1) c = 1;
         else if (c > 0) c++;
         if (c > 0 && cExp == 0 && latencyExpired === 1'b1) cExp = c - 1; // Edges after capture
         if (endTransaction === 1'b1) seenEnd = 1'b1;
      end
      check(32'(cExp), en ? (lat == 8'h00 ? 32'h1 : {24'h0, lat}) : 32'h0);
      check({31'h0, seenEnd}, {31'h0, en});
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      #(25.0 * 20000);
      n_errors++;
      report_and_stop;
   end
   initial begin
      {cfgFunc, cfgWrite, cfgRead, decodeFunc, latFunc, go, resetn, n_errors, checked} = '0;
      {cfgAddr, decodeBus, cfgByteEn, len, cfgWriteData, decodeAddr} = '0;
      {memWin0Prefetchable, memWin1Prefetchable} = '0;
      foreach (shadow[i, j]) shadow[i][j] = 32'h0;
      void'($urandom(24));
      repeat (3) @(negedge clock);
      resetn = 1'b1;
      repeat (3) @(negedge clock);
      for (k = 0; k < 20; k++) cfg_check(k[0], k / 2 < 9 ? OFFS[k / 2] : 8'h40);
      decode(1'b1, 32'h00000000, 8'h00);
      repeat (60) begin
         f = 1'($urandom);
         k = $urandom % 10;
         cfg_write(f, k < 9 ? OFFS[k] : 8'h40, $urandom, 4'($urandom));
         cfg_check(f, k < 9 ? OFFS[k] : 8'h40);
         cfg_check(!f, k < 9 ? OFFS[k] : 8'h40);
      end
      for (k = 0; k < 4; k++) begin
         f = k[1];
         w = k % 2;
         z = (k < 3) ? 32'hFFFFFFFF : 32'h0;
         b = $urandom & z;
         cfg_write(f, OFFS[1+2*w], b, 4'hF);
         cfg_write(f, OFFS[2+2*w], (b + (($urandom % 4) << 12)) & z, 4'hF);
         b = $urandom & z;
         cfg_write(f, OFFS[5+2*w], b, 4'hF);
         cfg_write(f, OFFS[6+2*w], (b + ($urandom & 32'hFC)) & z, 4'hF);
         b = $urandom % 200;
         cfg_write(f, OFFS[0], {8'h0, 8'(b + $urandom % 8), b[7:0], 8'($urandom)}, 4'h7);
      end
      repeat (300) begin
         f = 1'($urandom);
         w = $urandom % 2;
         case ($urandom % 8)
            0: b = shadow[f][1+2*w];
            1: b = shadow[f][2+2*w] | cardbus_window_pkg::MEM_LOW_ONES;
            2: b = (shadow[f][2+2*w] | cardbus_window_pkg::MEM_LOW_ONES) + 1;
            3: b = shadow[f][1+2*w] - 1;
            4: b = shadow[f][5+2*w];
            5: b = shadow[f][6+2*w] | cardbus_window_pkg::IO_LOW_ONES;
            6: b = (shadow[f][6+2*w] | cardbus_window_pkg::IO_LOW_ONES) + 1;
            default: b = $urandom;
         endcase
         decode(f, b, 8'(shadow[f][0] >> (8 * ($urandom % 3))) + 8'($urandom % 3) - 8'h1);
      end
      for (k = 0; k < 6; k++) run_tx(k[0], k < 3 ? 8'(k) : 8'(3 + $urandom % 6), 4'hF, 1'b1);
      run_tx(1'b1, cardbus_window_pkg::LAT_RECOMMENDED, 4'h3, 1'b0);
      report_and_stop;
   end
endmodule
`default_nettype wire
